// ---- rtl/iap_flash_ctrl.sv ----
// In-application flash erase, write and read sequencer
`timescale 1ns/1ps
module iap_flash_ctrl #(
  parameter int ERASE_CYCLES_0 = iap_pkg::ERASE_CYC_0,
  parameter int WRITE_CYCLES_0 = iap_pkg::WRITE_CYC_0,
  parameter int ERASE_CYCLES_1 = iap_pkg::ERASE_CYC_1,
  parameter int WRITE_CYCLES_1 = iap_pkg::WRITE_CYC_1,
  parameter int UNLOCK_CYCLES = iap_pkg::UNLOCK_CYC,
  parameter logic [15:0] KEY1 = 16'h1234,
  parameter logic [15:0] KEY2 = 16'h5678,
  parameter logic [15:0] KEY3 = 16'h9abc
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic cpu_halt,
  output logic chip_reset,
  output logic [12:0] flash_addr,
  output logic [15:0] flash_wdata,
  output logic flash_prog,
  output logic flash_erase,
  output logic flash_read,
  input wire logic [15:0] flash_rdata
);
  // ==========================================================
  // Registers
  logic ewen, unlock, wstart, rpermit, rstart, ptsel, clrreq;
  logic [2:0] mode;
  logic [7:0] reset_pat;
  logic [12:0] faddr;
  logic [15:0] dw [4];
  logic [31:0] timer;
  logic [31:0] utimer;
  logic [4:0] widx;
  logic [4:0] next_widx;
  logic [12:0] next_faddr;
  logic [2:0] key_step;
  iap_pkg::op_state_t st;
  logic [15:0] buf_data;
  logic buf_tag;

  function automatic logic [12:0] bump(input logic [12:0] a);
    if (a[4:0] == iap_pkg::LAST_WORD) begin
      return a;
    end
    return a + 13'h0001;
  endfunction : bump

  // ==========================================================
  // Decode
  wire wr_main = reg_wr && (reg_addr == iap_pkg::REG_CTRL_MAIN);
  wire wr_aux = reg_wr && (reg_addr == iap_pkg::REG_CTRL_AUX);
  wire wr_d0h = reg_wr && (reg_addr == iap_pkg::REG_D0H);
  wire idle = (st == iap_pkg::ST_IDLE);
  wire buf_load = wr_d0h && ewen;
  wire [15:0] d0_pair = {reg_wdata, dw[0][7:0]};
  wire [15:0] prog_word = buf_tag ? buf_data : 16'h0000;
  wire start_wr = idle && wstart && ewen && (mode == iap_pkg::MODE_WRITE);
  wire start_er = idle && wstart && ewen && (mode == iap_pkg::MODE_ERASE);
  wire start_rd = idle && rstart && rpermit && (mode == iap_pkg::MODE_READ);
  wire [31:0] prog_len = ptsel ? 32'(WRITE_CYCLES_1) : 32'(WRITE_CYCLES_0);
  wire [31:0] erase_len = ptsel ? 32'(ERASE_CYCLES_1) : 32'(ERASE_CYCLES_0);
  wire timer_done = (timer == 32'h0000_0001);
  wire write_word_done = (st == iap_pkg::ST_WRITE) && timer_done;
  wire unlock_ok = unlock && (key_step == 3'h3);
  assign next_faddr = bump(faddr);
  assign next_widx = widx + 5'h01;

  iap_page_buffer #(.WORDS(iap_pkg::PAGE_WORDS), .AW(5)) u_buf (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(buf_load),
    .wr_idx(faddr[4:0]),
    .wr_data(d0_pair),
    .clear(clrreq || write_word_done),
    .rd_idx(widx),
    .rd_data(buf_data),
    .rd_tag(buf_tag)
  );

  // ==========================================================
  // Control register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ewen <= 1'b0;
      mode <= 3'h0;
      unlock <= 1'b0;
      wstart <= 1'b0;
      rpermit <= 1'b0;
      rstart <= 1'b0;
    end else begin
      if (wr_main) begin
        mode <= reg_wdata[iap_pkg::BIT_MODE_HI:iap_pkg::BIT_MODE_LO];
        rpermit <= reg_wdata[iap_pkg::BIT_RPERMIT];
      end
      if (unlock_ok) begin
        ewen <= 1'b1;
      end else if (wr_main && !reg_wdata[iap_pkg::BIT_EWEN]) begin
        ewen <= 1'b0;
      end
      if (unlock && (utimer == 32'h0000_0001 || unlock_ok)) begin
        unlock <= 1'b0;
      end else if (wr_main && reg_wdata[iap_pkg::BIT_UNLOCK]
                   && reg_wdata[iap_pkg::BIT_MODE_HI:iap_pkg::BIT_MODE_LO]
                      == iap_pkg::MODE_UNLOCK) begin
        unlock <= 1'b1;
      end
      if (write_word_done
          || (st == iap_pkg::ST_ERASE && timer_done)
          || (idle && wstart && !(start_wr || start_er))) begin
        wstart <= 1'b0;
      end else if (wr_main && reg_wdata[iap_pkg::BIT_WSTART]) begin
        wstart <= 1'b1;
      end
      if ((st == iap_pkg::ST_READ && timer_done) || (idle && rstart && !start_rd)) begin
        rstart <= 1'b0;
      end else if (wr_main && reg_wdata[iap_pkg::BIT_RSTART]) begin
        rstart <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Aux, reset pattern, address, data
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ptsel <= 1'b0;
      clrreq <= 1'b0;
      reset_pat <= iap_pkg::RESET_BYTE;
      faddr <= '0;
      chip_reset <= 1'b0;
    end else begin
      chip_reset <= reg_wr && reg_addr == iap_pkg::REG_RESET_PAT
                    && reg_wdata == iap_pkg::CHIP_RESET_KEY;
      if (reg_wr && reg_addr == iap_pkg::REG_RESET_PAT) begin
        reset_pat <= reg_wdata;
      end
      if (wr_aux) begin
        ptsel <= reg_wdata[iap_pkg::BIT_PTSEL];
        clrreq <= reg_wdata[iap_pkg::BIT_CLRREQ];
      end else if (clrreq) begin
        clrreq <= 1'b0;
      end
      if (reg_wr && reg_addr == iap_pkg::REG_ADDR_LOW) begin
        faddr[7:0] <= reg_wdata;
      end else if (reg_wr && reg_addr == iap_pkg::REG_ADDR_HIGH) begin
        faddr[12:8] <= reg_wdata[4:0];
      end else if (buf_load) begin
        faddr <= next_faddr;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dw[0] <= '0;
      dw[1] <= '0;
      dw[2] <= '0;
      dw[3] <= '0;
    end else if (st == iap_pkg::ST_READ && timer_done) begin
      dw[0] <= flash_rdata;
    end else if (reg_wr && reg_addr >= iap_pkg::REG_D0L && reg_addr <= iap_pkg::REG_D3H) begin
      if (reg_addr[0]) begin
        dw[2'((reg_addr - iap_pkg::REG_D0L) >> 1)][7:0] <= reg_wdata;
      end else begin
        dw[2'((reg_addr - iap_pkg::REG_D0L) >> 1)][15:8] <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // Unlock key sequence and timer
  always_ff @(posedge clk_sys) begin
    if (rst || !unlock) begin
      key_step <= 3'h0;
      utimer <= 32'(UNLOCK_CYCLES);
    end else begin
      utimer <= utimer - 32'h0000_0001;
      if (reg_wr && reg_addr == iap_pkg::REG_D1H && key_step == 3'h0
          && {reg_wdata, dw[1][7:0]} == KEY1) begin
        key_step <= 3'h1;
      end else if (reg_wr && reg_addr == iap_pkg::REG_D2H && key_step == 3'h1
                   && {reg_wdata, dw[2][7:0]} == KEY2) begin
        key_step <= 3'h2;
      end else if (reg_wr && reg_addr == iap_pkg::REG_D3H && key_step == 3'h2
                   && {reg_wdata, dw[3][7:0]} == KEY3) begin
        key_step <= 3'h3;
      end
    end
  end

  // ==========================================================
  // Operation sequencer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= iap_pkg::ST_IDLE;
      timer <= '0;
      widx <= '0;
    end else begin
      case (st)
        iap_pkg::ST_IDLE: begin
          widx <= '0;
          if (start_wr) begin
            st <= iap_pkg::ST_WRITE;
            timer <= prog_len;
          end else if (start_er) begin
            st <= iap_pkg::ST_ERASE;
            timer <= erase_len;
          end else if (start_rd) begin
            st <= iap_pkg::ST_READ;
            timer <= 32'(iap_pkg::READ_CYC);
          end
        end
        iap_pkg::ST_WRITE: begin
          timer <= timer - 32'h0000_0001;
          widx <= (widx == iap_pkg::LAST_WORD) ? widx : next_widx;
          if (timer_done) begin
            st <= iap_pkg::ST_CLEAR;
          end
        end
        iap_pkg::ST_ERASE, iap_pkg::ST_READ: begin
          timer <= timer - 32'h0000_0001;
          if (timer_done) begin
            st <= iap_pkg::ST_IDLE;
          end
        end
        iap_pkg::ST_CLEAR: begin
          st <= iap_pkg::ST_IDLE;
        end
        default: begin
          st <= iap_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Flash array strobes and CPU stall
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flash_addr <= '0;
      flash_wdata <= '0;
      flash_prog <= 1'b0;
      flash_erase <= 1'b0;
      flash_read <= 1'b0;
    end else begin
      flash_addr <= (st == iap_pkg::ST_READ) ? faddr : {faddr[12:5], widx};
      flash_wdata <= prog_word;
      flash_prog <= start_wr;
      flash_erase <= start_er;
      flash_read <= start_rd;
    end
  end
  assign cpu_halt = !idle;

  // ==========================================================
  // Read-back
  always_comb begin
    reg_rdata = 8'h00;
    if (reg_addr == iap_pkg::REG_CTRL_MAIN) begin
      reg_rdata = {ewen, mode, unlock, wstart, rpermit, rstart};
    end else if (reg_addr == iap_pkg::REG_RESET_PAT) begin
      reg_rdata = reset_pat;
    end else if (reg_addr == iap_pkg::REG_CTRL_AUX) begin
      reg_rdata = {6'h00, ptsel, clrreq};
    end else if (reg_addr == iap_pkg::REG_ADDR_LOW) begin
      reg_rdata = faddr[7:0];
    end else if (reg_addr == iap_pkg::REG_ADDR_HIGH) begin
      reg_rdata = {3'h0, faddr[12:8]};
    end else if (reg_addr >= iap_pkg::REG_D0L && reg_addr <= iap_pkg::REG_D3H) begin
      reg_rdata = reg_addr[0] ? dw[2'((reg_addr - iap_pkg::REG_D0L) >> 1)][7:0]
                              : dw[2'((reg_addr - iap_pkg::REG_D0L) >> 1)][15:8];
    end
  end
endmodule : iap_flash_ctrl

// ---- rtl/iap_pkg.sv ----
// Constants for the in-application flash programming controller
package iap_pkg;
  // ==========================================================
  // Register indices
  localparam logic [3:0] REG_CTRL_MAIN = 4'h0;
  localparam logic [3:0] REG_RESET_PAT = 4'h1;
  localparam logic [3:0] REG_CTRL_AUX = 4'h2;
  localparam logic [3:0] REG_ADDR_LOW = 4'h3;
  localparam logic [3:0] REG_ADDR_HIGH = 4'h4;
  localparam logic [3:0] REG_D0L = 4'h5;
  localparam logic [3:0] REG_D0H = 4'h6;
  localparam logic [3:0] REG_D1L = 4'h7;
  localparam logic [3:0] REG_D1H = 4'h8;
  localparam logic [3:0] REG_D2L = 4'h9;
  localparam logic [3:0] REG_D2H = 4'ha;
  localparam logic [3:0] REG_D3L = 4'hb;
  localparam logic [3:0] REG_D3H = 4'hc;
  // ==========================================================
  // Control main and aux bit positions
  localparam int BIT_EWEN = 7;
  localparam int BIT_MODE_HI = 6;
  localparam int BIT_MODE_LO = 4;
  localparam int BIT_UNLOCK = 3;
  localparam int BIT_WSTART = 2;
  localparam int BIT_RPERMIT = 1;
  localparam int BIT_RSTART = 0;
  localparam int BIT_PTSEL = 1;
  localparam int BIT_CLRREQ = 0;
  // ==========================================================
  // Modes and constants
  localparam logic [2:0] MODE_WRITE = 3'h0;
  localparam logic [2:0] MODE_ERASE = 3'h1;
  localparam logic [2:0] MODE_READ = 3'h3;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;
  localparam logic [7:0] CHIP_RESET_KEY = 8'h55;
  localparam logic [4:0] LAST_WORD = 5'h1f;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int PAGE_WORDS = 32;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int ERASE_US_0 = 3200;
  localparam int WRITE_US_0 = 2200;
  localparam int ERASE_US_1 = 3700;
  localparam int WRITE_US_1 = 3000;
  localparam int ERASE_CYC_0 = ERASE_US_0 * CLK_MHZ;
  localparam int WRITE_CYC_0 = WRITE_US_0 * CLK_MHZ;
  localparam int ERASE_CYC_1 = ERASE_US_1 * CLK_MHZ;
  localparam int WRITE_CYC_1 = WRITE_US_1 * CLK_MHZ;
  localparam int UNLOCK_CYC = 1024;
  localparam int READ_CYC = 2;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_WRITE = 5'b00010,
    ST_ERASE = 5'b00100,
    ST_READ = 5'b01000,
    ST_CLEAR = 5'b10000
  } op_state_t;
endpackage : iap_pkg

// ---- rtl/iap_page_buffer.sv ----
// Page write buffer with per-word valid tags
`timescale 1ns/1ps
module iap_page_buffer #(
  parameter int WORDS = 32,
  parameter int AW = 5
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic clear,
  input wire logic [AW-1:0] rd_idx,
  output logic [15:0] rd_data,
  output logic rd_tag
);
  logic [15:0] mem [WORDS];
  logic [WORDS-1:0] tag;
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst || clear) begin
      tag <= '0;
    end else if (wr_en) begin
      tag[wr_idx] <= 1'b1;
    end
  end
  assign rd_data = mem[rd_idx];
  assign rd_tag = tag[rd_idx];
endmodule : iap_page_buffer

// ---- test/iap_flash_ctrl_checker.sv ----
// Port assertions for the flash programming controller
`timescale 1ns/1ps
module iap_flash_ctrl_checker #(
  parameter int ERASE_CYCLES_0 = 20,
  parameter int ERASE_CYCLES_1 = 20
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic cpu_halt,
  input wire logic chip_reset,
  input wire logic [12:0] flash_addr,
  input wire logic flash_prog,
  input wire logic flash_erase,
  input wire logic flash_read
);
  localparam int HALT_MAX = ERASE_CYCLES_0 + ERASE_CYCLES_1 + 16;
  logic permit;
  int halt_cnt;
  // ==========================================
  // Shadow of read permit and halt length
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      permit <= 1'b0;
    end else if (reg_wr && reg_addr == iap_pkg::REG_CTRL_MAIN) begin
      permit <= reg_wdata[iap_pkg::BIT_RPERMIT];
    end
  end
  always_ff @(posedge clk_sys) begin
    halt_cnt <= (rst || !cpu_halt) ? 0 : halt_cnt + 1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========================================
  // Assertions
  property p_reset_pulse;
    reg_wr && reg_addr == iap_pkg::REG_RESET_PAT && reg_wdata == iap_pkg::CHIP_RESET_KEY
      |=> chip_reset;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("chip reset missing");
  property p_reset_cause;
    chip_reset |-> $past(reg_wr && reg_addr == iap_pkg::REG_RESET_PAT
      && reg_wdata == iap_pkg::CHIP_RESET_KEY);
  endproperty
  a_reset_cause: assert property (p_reset_cause) else $error("chip reset uncaused");
  property p_op_halt;
    flash_prog || flash_erase |-> cpu_halt;
  endproperty
  a_op_halt: assert property (p_op_halt) else $error("operation without halt");
  property p_read_permit;
    flash_read |-> permit && cpu_halt;
  endproperty
  a_read_permit: assert property (p_read_permit) else $error("read without permit");
  property p_one_op;
    $onehot0({flash_prog, flash_erase, flash_read});
  endproperty
  a_one_op: assert property (p_one_op) else $error("two operations at once");
  property p_prog_once;
    flash_prog |=> !flash_prog [*8];
  endproperty
  a_prog_once: assert property (p_prog_once) else $error("page programmed twice");
  property p_page_stable;
    cpu_halt && $past(cpu_halt) |-> $stable(flash_addr[12:5]);
  endproperty
  a_page_stable: assert property (p_page_stable) else $error("page moved in op");
  property p_halt_bound;
    halt_cnt <= HALT_MAX;
  endproperty
  a_halt_bound: assert property (p_halt_bound) else $error("halt never ends");
  property p_halt_cause;
    $rose(cpu_halt) |-> $past(reg_wr) || $past(reg_wr, 2);
  endproperty
  a_halt_cause: assert property (p_halt_cause) else $error("halt without start");
endmodule : iap_flash_ctrl_checker
bind iap_flash_ctrl iap_flash_ctrl_checker #(
  .ERASE_CYCLES_0(ERASE_CYCLES_0),
  .ERASE_CYCLES_1(ERASE_CYCLES_1)
) i_iap_flash_ctrl_checker (
  .clk_sys(clk_sys),
  .rst(rst),
  .reg_wr(reg_wr),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .cpu_halt(cpu_halt),
  .chip_reset(chip_reset),
  .flash_addr(flash_addr),
  .flash_prog(flash_prog),
  .flash_erase(flash_erase),
  .flash_read(flash_read)
);

// ---- test/flash_array_model.sv ----
// Behavioural flash array facing the controller
`timescale 1ns/1ps
module flash_array_model (
  input wire logic clk_sys,
  input wire logic [12:0] flash_addr,
  input wire logic flash_erase,
  input wire logic flash_read,
  output logic [15:0] flash_rdata
);
  logic [255:0] erased = '0;
  logic [15:0] word;
  int hold = 0;
  // ==========================================
  // Word valid only shortly after a read strobe
  assign word = erased[flash_addr[12:5]] ? 16'h0000 : {3'h0, flash_addr} ^ 16'h5a3c;
  assign flash_rdata = (flash_read || hold != 0) ? word : ~word;
  always @(posedge clk_sys) begin
    if (flash_erase) begin
      erased[flash_addr[12:5]] <= 1'b1;
    end
    hold <= flash_read ? 4 : (hold > 0 ? hold - 1 : 0);
  end
endmodule : flash_array_model

// ---- test/iap_flash_erase_write_read_control_tb.sv ----
// Self-checking bench for the flash programming controller
`timescale 1ns/1ps
module iap_flash_erase_write_read_control_tb;
  localparam int E0 = 40;
  localparam int W0 = 24;
  localparam int E1 = 48;
  localparam int W1 = 32;
  localparam logic [15:0] K1 = 16'h1234;
  localparam logic [15:0] K2 = 16'h5678;
  localparam logic [15:0] K3 = 16'h9abc;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic cpu_halt, chip_reset, flash_prog, flash_erase, flash_read;
  logic [12:0] flash_addr;
  logic [15:0] flash_wdata, flash_rdata;
  logic [31:0] seed = 32'h8c72148a;
  int err_count = 0;
  int comparisons = 0;
  int n_rst = 0, n_prog = 0, n_read = 0;
  int tm [4] = '{E0, E1, W0, W1};
  logic [7:0] v;
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    n_rst <= n_rst + int'(chip_reset === 1'b1);
    n_prog <= n_prog + int'(flash_prog === 1'b1);
    n_read <= n_read + int'(flash_read === 1'b1);
  end
  iap_flash_ctrl #(.ERASE_CYCLES_0(E0), .WRITE_CYCLES_0(W0), .ERASE_CYCLES_1(E1),
    .WRITE_CYCLES_1(W1), .UNLOCK_CYCLES(64), .KEY1(K1), .KEY2(K2), .KEY3(K3)) i_iap_flash_ctrl (
    .clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cpu_halt(cpu_halt),
    .chip_reset(chip_reset), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_prog(flash_prog), .flash_erase(flash_erase), .flash_read(flash_read),
    .flash_rdata(flash_rdata));
  flash_array_model i_flash_array_model (.clk_sys(clk_sys), .flash_addr(flash_addr),
    .flash_erase(flash_erase), .flash_read(flash_read), .flash_rdata(flash_rdata));
  // ==========================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    #1 d = reg_rdata;
  endtask : rd
  task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(what, {8'h00, d}, {8'h00, exp});
  endtask : rchk
  task automatic run(input logic [7:0] ctl, output int n);
    wr(4'h0, ctl);
    n = 0;
    @(posedge clk_sys);
    #1;
    while (cpu_halt === 1'b1 && n < 5000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask : run
  task automatic stop_test();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  // ==========================================
  // Scenarios
  initial begin
    int n;
    logic [7:0] pg;
    logic [15:0] w;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 0; a < 14; a++) begin
      rchk("reset value", a[3:0], 8'h00);
    end
    wr(4'h1, 8'h54);
    wr(4'h1, 8'h55);
    repeat (2) @(posedge clk_sys);
    chk("chip resets", 16'(n_rst), 16'd1);
    wr(4'h0, 8'h80);
    rchk("flag by software", 4'h0, 8'h00);
    pg = 8'(rnd());
    wr(4'h3, {pg[2:0], 5'h1d});
    wr(4'h4, {3'h0, pg[7:3]});
    run(8'h31, n);
    repeat (2) @(posedge clk_sys);
    chk("refused read", 16'(n + n_read), 16'd0);
    rchk("refused start", 4'h0, 8'h30);
    run(8'h32, n);
    run(8'h33, n);
    w = {3'h0, pg, 5'h1d} ^ 16'h5a3c;
    rchk("read low", 4'h5, w[7:0]);
    rchk("read high", 4'h6, w[15:8]);
    rchk("read done", 4'h0, 8'h32);
    chk("read strobes", 16'(n_read), 16'd1);
    wr(4'h0, 8'h68);
    wr(4'h7, K1[7:0]);
    wr(4'h8, K1[15:8]);
    wr(4'h9, K2[7:0]);
    wr(4'ha, K2[15:8]);
    wr(4'hb, K3[7:0]);
    wr(4'hc, K3[15:8]);
    n = 0;
    rd(4'h0, v);
    while (v[3] !== 1'b0 && n < 200) begin
      rd(4'h0, v);
      n++;
    end
    chk("unlock", {8'h00, v}, 16'h00e0);
    wr(4'h2, 8'h01);
    rchk("clear request", 4'h2, 8'h00);
    wr(4'h3, {pg[2:0], 5'h1d});
    for (int i = 0; i < 4; i++) begin
      wr(4'h5, 8'(rnd()));
      wr(4'h6, 8'(rnd()));
      rchk("address low", 4'h3, {pg[2:0], (i == 0) ? 5'h1e : 5'h1f});
    end
    rchk("address high", 4'h4, {3'h0, pg[7:3]});
    for (int k = 0; k < 4; k++) begin
      wr(4'h2, {6'h00, k[0], 1'b0});
      run(k[1] ? 8'h84 : 8'h94, n);
      chk("op time", 16'(n >= tm[k] && n <= tm[k] + 3), 16'd1);
      rchk("start done", 4'h0, k[1] ? 8'h80 : 8'h90);
    end
    chk("program strobes", 16'(n_prog), 16'd2);
    run(8'h32, n);
    run(8'h33, n);
    rchk("erased low", 4'h5, 8'h00);
    rchk("erased high", 4'h6, 8'h00);
    run(8'h04, n);
    repeat (2) @(posedge clk_sys);
    chk("locked write", 16'(n + n_prog), 16'd2);
    wr(4'h3, {pg[2:0], 5'h00});
    wr(4'h6, 8'h11);
    rchk("locked load", 4'h3, {pg[2:0], 5'h00});
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    stop_test();
  end
endmodule : iap_flash_erase_write_read_control_tb
